// ==== include/rsa_pkg.sv ====
// Package for the receive-sequencing and synthesizer-A configuration bank.
// Assumes an 8-bit register port and a 25 MHz crystal-derived system clock.
package rsa_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 8;
   // Register offsets
   localparam logic [7:0]  OFS_SEQ_TIMING  = 8'h03;
   localparam logic [7:0]  OFS_WORD_HIGH   = 8'h04;
   localparam logic [7:0]  OFS_WORD_MID    = 8'h05;
   localparam logic [7:0]  OFS_WORD_LOW    = 8'h06;
   localparam logic [7:0]  OFS_CLK_DIV_A   = 8'h07;
   localparam logic [7:0]  OFS_SEQ_CTRL    = 8'h10;
   localparam logic [7:0]  OFS_SEQ_STATUS  = 8'h11;
   // Reset values
   localparam logic [7:0]  RST_SEQ_TIMING  = 8'h8A;
   localparam logic [7:0]  RST_WORD_HIGH   = 8'h83;
   localparam logic [7:0]  RST_WORD_MID    = 8'hB1;
   localparam logic [7:0]  RST_WORD_LOW    = 8'hF9;
   localparam logic [7:0]  RST_CLK_DIV_A   = 8'h50;
   localparam logic [7:0]  RST_SEQ_CTRL    = 8'h00;
   // Field positions
   localparam int          SEQ_TRIG_BIT    = 7;
   localparam int          RXW_HI          = 6;
   localparam int          RXW_LO          = 4;
   localparam int          CSW_HI          = 3;
   localparam int          CSW_LO          = 0;
   localparam int          REFDIV_HI       = 7;
   localparam int          REFDIV_LO       = 5;
   localparam int          MDIV1_HI        = 4;
   localparam int          MDIV1_LO        = 2;
   localparam int          MDIV2_HI        = 1;
   localparam int          MDIV2_LO        = 0;
   localparam int          PDMODE_HI       = 1;
   localparam int          PDMODE_LO       = 0;
   localparam int          SPLIT_BIT       = 2;
   localparam logic [1:0]  PDMODE_AUTO_SEQ = 2'h3;
   localparam logic [2:0]  RXW_NO_WAIT     = 3'h7;
   localparam logic [2:0]  REFDIV_UNSUPP   = 3'h0;
   localparam logic [2:0]  BAUD_PER_MODEM  = 3'h7;
   localparam logic [10:0] HALF_STEP       = 11'h002;
   typedef enum logic [2:0] {
      RSA_IDLE    = 3'b000,
      RSA_LOCK    = 3'b001,
      RSA_RX_WAIT = 3'b010,
      RSA_CS_WAIT = 3'b011,
      RSA_RX_HOLD = 3'b100
   } rsa_state_t;
endpackage : rsa_pkg

// ==== rtl/rsa_seq_config.sv ====
// Configuration bank with power-up sequencer and modem clock dividers for setting A.
// Assumes a host register port on sys_clk_i; pins and radio status arrive asynchronously.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module rsa_seq_config
   import rsa_pkg::*;
#(
   parameter int ADC_DIV    = 8,   // Crystal cycles per converter clock
   parameter int FILTER_DIV = 16   // Crystal cycles per channel-filter clock
) (
   input  wire logic              sys_clk_i,      // Crystal-rate clock
   input  wire logic              rst_i,          // Async reset, high
   input  wire logic [ADDR_W-1:0] addr_i,         // Register address
   input  wire logic [DATA_W-1:0] wr_data_i,      // Write data
   input  wire logic              wr_i,           // Write strobe
   input  wire logic              rd_i,           // Read strobe
   output logic      [DATA_W-1:0] rd_data_o,      // Read data, cycle after strobe
   input  wire logic              cfg_select_i,   // Select pin level
   input  wire logic              bidir_data_pin_i, // Data pin input level
   input  wire logic              synth_lock_i,   // Synthesizer lock
   input  wire logic              carrier_sense_i, // Carrier sensed
   output logic                   synth_en_o,     // Synthesizer powered
   output logic                   rx_en_o,        // Receiver powered
   output logic                   seq_active_o,   // Sequence in progress
   output logic [22:0]            synth_word_a_o, // Frequency word A
   output logic                   synth_a_dither_enable_o, // Dither for A
   output logic                   ref_tick_o,     // Reference clock pulse
   output logic                   modem_tick_o,   // Modem clock pulse
   output logic                   symbol_tick_o   // Symbol rate pulse
);

   // Wait in converter periods after lock
   function automatic logic [8:0] rx_wait_len(input logic [2:0] code);
      logic [8:0] n;
      n = 9'h020;
      unique case (code)
         3'h0: n = 9'h020;
         3'h1: n = 9'h02C;
         3'h2: n = 9'h040;
         3'h3: n = 9'h058;
         3'h4: n = 9'h080;
         3'h5: n = 9'h0B0;
         3'h6: n = 9'h100;
         3'h7: n = 9'h000;
      endcase
      return n;
   endfunction : rx_wait_len

   // Carrier window in filter periods
   function automatic logic [6:0] cs_wait_len(input logic [3:0] code);
      logic [6:0] n;
      if (code == 4'hF) begin
         n = 7'h48;
      end else if (code > 4'h6) begin
         n = 7'(7'h24 + {1'b0, code - 4'h7, 2'b00});
      end else begin
         n = 7'(7'h14 + {2'b00, code, 1'b0});
      end
      return n;
   endfunction : cs_wait_len

   // First modem divider in half units
   function automatic logic [7:0] mdiv1_half(input logic [2:0] code);
      logic [7:0] h;
      h = 8'h05;
      unique case (code)
         3'h0: h = 8'h05;
         3'h1: h = 8'h06;
         3'h2: h = 8'h08;
         3'h3: h = 8'h0F;
         3'h4: h = 8'h19;
         3'h5: h = 8'h50;
         3'h6: h = 8'h60;
         3'h7: h = 8'h80;
      endcase
      return h;
   endfunction : mdiv1_half

   // Register file
   logic [7:0] seq_timing_q;
   logic [7:0] word_high_q;
   logic [7:0] word_mid_q;
   logic [7:0] word_low_q;
   logic [7:0] clk_div_a_q;
   logic [7:0] seq_ctrl_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         seq_timing_q <= RST_SEQ_TIMING;
         word_high_q  <= RST_WORD_HIGH;
         word_mid_q   <= RST_WORD_MID;
         word_low_q   <= RST_WORD_LOW;
         clk_div_a_q  <= RST_CLK_DIV_A;
         seq_ctrl_q   <= RST_SEQ_CTRL;
      end else if (wr_i) begin
         unique case (addr_i)
            OFS_SEQ_TIMING: seq_timing_q <= wr_data_i;
            OFS_WORD_HIGH:  word_high_q  <= wr_data_i;
            OFS_WORD_MID:   word_mid_q   <= wr_data_i;
            OFS_WORD_LOW:   word_low_q   <= wr_data_i;
            OFS_CLK_DIV_A:  clk_div_a_q  <= wr_data_i;
            OFS_SEQ_CTRL:   seq_ctrl_q   <= wr_data_i;
            default: ;
         endcase
      end
   end

   rsa_state_t state_q;

   // Read port; data shows only in the cycle after the strobe
   // Status is read-only: a write to its offset falls into the default branch
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= '0;
      end else if (rd_i) begin
         unique case (addr_i)
            OFS_SEQ_TIMING: rd_data_o <= seq_timing_q;
            OFS_WORD_HIGH:  rd_data_o <= word_high_q;
            OFS_WORD_MID:   rd_data_o <= word_mid_q;
            OFS_WORD_LOW:   rd_data_o <= word_low_q;
            OFS_CLK_DIV_A:  rd_data_o <= clk_div_a_q;
            OFS_SEQ_CTRL:   rd_data_o <= seq_ctrl_q;
            OFS_SEQ_STATUS: rd_data_o <= {5'h00, state_q};
            default:        rd_data_o <= '0;
         endcase
      end else begin
         rd_data_o <= '0;
      end
   end

   // Word A and dither drive the synthesizer straight from flops
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         synth_word_a_o          <= {RST_WORD_HIGH, RST_WORD_MID, RST_WORD_LOW[7:1]};
         synth_a_dither_enable_o <= RST_WORD_LOW[0];
      end else begin
         synth_word_a_o          <= {word_high_q, word_mid_q, word_low_q[7:1]};
         synth_a_dither_enable_o <= word_low_q[0];
      end
   end

   // Two-flop synchronisers, with a third stage for edge detection on the two pins only
   // Edge stages reset high, the idle pin level, so leaving reset shows no false fall
   logic [2:0] sel_sync_q;
   logic [2:0] dio_sync_q;
   logic [1:0] lock_sync_q;
   logic [1:0] cs_sync_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel_sync_q  <= 3'h7;
         dio_sync_q  <= 3'h7;
         lock_sync_q <= 2'h0;
         cs_sync_q   <= 2'h0;
      end else begin
         sel_sync_q  <= {sel_sync_q[1:0], cfg_select_i};
         dio_sync_q  <= {dio_sync_q[1:0], bidir_data_pin_i};
         lock_sync_q <= {lock_sync_q[0], synth_lock_i};
         cs_sync_q   <= {cs_sync_q[0], carrier_sense_i};
      end
   end

   logic sel_fall;
   logic dio_fall;
   logic trig;
   logic seq_trigger_on_select;
   logic split_data_output;
   logic [1:0] powerdown_mode_field;

   assign seq_trigger_on_select = seq_timing_q[SEQ_TRIG_BIT];
   assign split_data_output     = seq_ctrl_q[SPLIT_BIT];
   assign powerdown_mode_field  = seq_ctrl_q[PDMODE_HI:PDMODE_LO];
   assign sel_fall = sel_sync_q[2] & ~sel_sync_q[1];
   assign dio_fall = dio_sync_q[2] & ~dio_sync_q[1];

   // Select pin only counts with the trigger bit set; data pin only without it
   assign trig = (seq_trigger_on_select & sel_fall)
               | (~seq_trigger_on_select & split_data_output
                  & (powerdown_mode_field == PDMODE_AUTO_SEQ)
                  & dio_fall);

   // Converter and filter clock enables from the crystal
   logic [7:0] adc_cnt_q;
   logic [7:0] flt_cnt_q;
   logic       adc_tick_q;
   logic       flt_tick_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         adc_cnt_q  <= '0;
         adc_tick_q <= 1'b0;
      end else if (adc_cnt_q == 8'(ADC_DIV - 1)) begin
         adc_cnt_q  <= '0;
         adc_tick_q <= 1'b1;
      end else begin
         adc_cnt_q  <= adc_cnt_q + 8'h01;
         adc_tick_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flt_cnt_q  <= '0;
         flt_tick_q <= 1'b0;
      end else if (flt_cnt_q == 8'(FILTER_DIV - 1)) begin
         flt_cnt_q  <= '0;
         flt_tick_q <= 1'b1;
      end else begin
         flt_cnt_q  <= flt_cnt_q + 8'h01;
         flt_tick_q <= 1'b0;
      end
   end

   // Power-up sequencer
   // Triggers are only taken in idle; edges during a sequence are dropped on purpose
   logic [8:0] wait_q;
   logic [2:0] rx_wait_code;
   logic [3:0] cs_wait_code;

   assign rx_wait_code = seq_timing_q[RXW_HI:RXW_LO];
   assign cs_wait_code = seq_timing_q[CSW_HI:CSW_LO];

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= RSA_IDLE;
         wait_q  <= '0;
      end else begin
         unique case (state_q)
            RSA_IDLE: begin
               if (trig) begin
                  state_q <= RSA_LOCK;
               end
            end
            RSA_LOCK: begin
               if (lock_sync_q[1]) begin
                  if (rx_wait_code == RXW_NO_WAIT) begin
                     state_q <= RSA_CS_WAIT;
                     wait_q  <= {2'b00, cs_wait_len(cs_wait_code)};
                  end else begin
                     state_q <= RSA_RX_WAIT;
                     wait_q  <= rx_wait_len(rx_wait_code);
                  end
               end
            end
            RSA_RX_WAIT: begin
               if (adc_tick_q) begin
                  if (wait_q == 9'h001) begin
                     state_q <= RSA_CS_WAIT;
                     wait_q  <= {2'b00, cs_wait_len(cs_wait_code)};
                  end else begin
                     wait_q <= wait_q - 9'h001;
                  end
               end
            end
            RSA_CS_WAIT: begin
               if (flt_tick_q) begin
                  if (wait_q == 9'h001) begin
                     // A sensed carrier keeps the receiver up
                     state_q <= cs_sync_q[1] ? RSA_RX_HOLD : RSA_IDLE;
                  end else begin
                     wait_q <= wait_q - 9'h001;
                  end
               end
            end
            RSA_RX_HOLD: begin
               if (!cs_sync_q[1]) begin
                  state_q <= RSA_IDLE;
               end
            end
            default: state_q <= RSA_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         synth_en_o   <= 1'b0;
         rx_en_o      <= 1'b0;
         seq_active_o <= 1'b0;
      end else begin
         synth_en_o   <= (state_q != RSA_IDLE);
         rx_en_o      <= (state_q == RSA_CS_WAIT) | (state_q == RSA_RX_HOLD);
         seq_active_o <= (state_q != RSA_IDLE);
      end
   end

   // Reference divider: crystal over code plus one
   logic [2:0] ref_div_code;
   logic [2:0] ref_cnt_q;

   assign ref_div_code = clk_div_a_q[REFDIV_HI:REFDIV_LO];

   // Unsupported code 0 gives a reference tick every crystal cycle rather than stalling the modem clock
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_cnt_q  <= '0;
         ref_tick_o <= 1'b0;
      end else if (ref_cnt_q >= ref_div_code || ref_div_code == REFDIV_UNSUPP) begin
         ref_cnt_q  <= '0;
         ref_tick_o <= 1'b1;
      end else begin
         ref_cnt_q  <= ref_cnt_q + 3'h1;
         ref_tick_o <= 1'b0;
      end
   end

   // Modem divider: phase accumulator in half units gives 2.5-type ratios
   // A ratio change keeps the accumulator, so the first modem periods may run short
   logic [10:0] half_total;
   logic [10:0] acc_q;
   logic [1:0]  mdiv2_code;
   logic [10:0] acc_next;

   assign mdiv2_code = clk_div_a_q[MDIV2_HI:MDIV2_LO];
   assign half_total = 11'({3'h0, mdiv1_half(clk_div_a_q[MDIV1_HI:MDIV1_LO])}
                           << mdiv2_code);
   assign acc_next   = acc_q + HALF_STEP;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_q        <= '0;
         modem_tick_o <= 1'b0;
      end else if (ref_tick_o) begin
         if (acc_next >= half_total) begin
            acc_q        <= acc_next - half_total;
            modem_tick_o <= 1'b1;
         end else begin
            acc_q        <= acc_next;
            modem_tick_o <= 1'b0;
         end
      end else begin
         modem_tick_o <= 1'b0;
      end
   end

   // Symbol rate: one pulse per eight modem pulses
   logic [2:0] sym_cnt_q;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sym_cnt_q     <= '0;
         symbol_tick_o <= 1'b0;
      end else if (modem_tick_o) begin
         sym_cnt_q     <= sym_cnt_q + 3'h1;
         symbol_tick_o <= (sym_cnt_q == BAUD_PER_MODEM);
      end else begin
         symbol_tick_o <= 1'b0;
      end
   end

endmodule : rsa_seq_config

// ==== verif/rsa_seq_config_sva.sv ====
// Checker for the setting-A configuration bank, bound to its top module.
// Assumes registers are changed only by host writes and mirrors the timing, divider and control registers here.
`timescale 1ns/1ps
module rsa_seq_config_sva
   import rsa_pkg::*;
#(
   parameter int ADC_DIV    = 8,  // Crystal cycles per converter clock
   parameter int FILTER_DIV = 16  // Crystal cycles per filter clock
) (
   input wire logic              sys_clk_i,               // Clock
   input wire logic              rst_i,                   // Reset
   input wire logic [ADDR_W-1:0] addr_i,                  // Address
   input wire logic [DATA_W-1:0] wr_data_i,               // Write data
   input wire logic              wr_i,                    // Write strobe
   input wire logic              cfg_select_i,            // Select pin
   input wire logic              bidir_data_pin_i,        // Data pin
   input wire logic              synth_lock_i,            // Lock
   input wire logic              carrier_sense_i,         // Carrier
   input wire logic              rx_en_o,                 // Receiver on
   input wire logic              seq_active_o,            // Sequence busy
   input wire logic [22:0]       synth_word_a_o,          // Word A
   input wire logic              synth_a_dither_enable_o, // Dither
   input wire logic              ref_tick_o,              // Reference tick
   input wire logic              modem_tick_o,            // Modem tick
   input wire logic              symbol_tick_o            // Symbol tick
);
   logic [7:0]  tim_q, div_q, ctl_q;
   logic [11:0] lk_q, rx_q, ref_q;
   logic [9:0]  mr_q;
   logic [3:0]  sm_q;
   logic [2:0]  mok_q;
   logic        cs_q, rok_q, div_wr;
   function automatic int rxw_n(input logic [2:0] c);
      int t[8] = '{32, 44, 64, 88, 128, 176, 256, 0};
      return t[c] * ADC_DIV;
   endfunction : rxw_n
   function automatic int csw_n(input logic [3:0] c);
      return (c < 7 ? 20 + 2 * int'(c) : c < 15 ? 36 + 4 * (int'(c) - 7) : 72) * FILTER_DIV;
   endfunction : csw_n
   function automatic int mod_half(input logic [7:0] d);
      int t[8] = '{5, 6, 8, 15, 25, 80, 96, 128};
      return t[d[4:2]] << d[1:0];
   endfunction : mod_half
   assign div_wr = wr_i && addr_i == OFS_CLK_DIV_A;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tim_q <= 8'h8A;
         div_q <= 8'h50;
         ctl_q <= 8'h00;
      end else if (wr_i) begin
         if (addr_i == OFS_SEQ_TIMING) tim_q <= wr_data_i;
         if (addr_i == OFS_CLK_DIV_A) div_q <= wr_data_i;
         if (addr_i == OFS_SEQ_CTRL) ctl_q <= wr_data_i;
      end
   end
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lk_q <= '0;
         rx_q <= '0;
         cs_q <= 1'b0;
      end else begin
         lk_q <= synth_lock_i ? lk_q + 12'h001 : '0;
         rx_q <= rx_en_o ? rx_q + 12'h001 : '0;
         cs_q <= rx_en_o && (cs_q || carrier_sense_i);
      end
   end
   // Divider phase after a ratio change is left open, so gaps are judged only later
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ref_q <= '0;
         mr_q  <= '0;
         sm_q  <= '0;
         rok_q <= 1'b0;
         mok_q <= '0;
      end else begin
         ref_q <= ref_tick_o ? '0 : ref_q + 12'h001;
         mr_q  <= modem_tick_o ? '0 : mr_q + 10'(ref_tick_o);
         sm_q  <= symbol_tick_o ? 4'(modem_tick_o) : sm_q + 4'(modem_tick_o);
         rok_q <= !div_wr && (rok_q || ref_tick_o);
         mok_q <= div_wr ? '0 : mok_q + 3'(modem_tick_o && mok_q != 3'h7);
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_word_high : assert property (
      wr_i && addr_i == OFS_WORD_HIGH |-> ##2 synth_word_a_o[22:15] == $past(wr_data_i, 2))
      else $error("word A high byte not applied");
   a_word_mid : assert property (
      wr_i && addr_i == OFS_WORD_MID |-> ##2 synth_word_a_o[14:7] == $past(wr_data_i, 2))
      else $error("word A mid byte not applied");
   a_word_low : assert property (
      wr_i && addr_i == OFS_WORD_LOW
      |-> ##2 {synth_word_a_o[6:0], synth_a_dither_enable_o} == $past(wr_data_i, 2))
      else $error("word A low bits or dither not applied");
   a_sel_start : assert property (
      $fell(cfg_select_i) && tim_q[7] && !seq_active_o |-> ##[3:7] seq_active_o)
      else $error("select pin fall did not start sequencing");
   a_data_start : assert property (
      $fell(bidir_data_pin_i) && !tim_q[7] && ctl_q[2] && ctl_q[1:0] == 2'h3 && !seq_active_o
      |-> ##[3:7] seq_active_o)
      else $error("data pin fall did not start sequencing");
   a_no_start : assert property (
      !tim_q[7] && !(ctl_q[2] && ctl_q[1:0] == 2'h3) && !seq_active_o |=> !seq_active_o)
      else $error("sequencing started without an enabled trigger");
   a_rx_delay : assert property (
      $rose(rx_en_o) |-> lk_q + ADC_DIV >= rxw_n(tim_q[6:4])
      && lk_q <= rxw_n(tim_q[6:4]) + ADC_DIV + 8)
      else $error("receiver power-up delay after lock wrong");
   a_cs_window : assert property (
      $fell(rx_en_o) && !cs_q |-> rx_q + FILTER_DIV >= csw_n(tim_q[3:0])
      && rx_q <= csw_n(tim_q[3:0]) + FILTER_DIV + 4)
      else $error("carrier window length wrong");
   a_ref_period : assert property (
      ref_tick_o && rok_q && div_q[7:5] != 3'h0 |-> ref_q == 12'(div_q[7:5]))
      else $error("reference tick period wrong");
   a_modem_ratio : assert property (
      modem_tick_o && mok_q == 3'h7 |-> (mr_q + ref_tick_o) * 2 + 1 >= mod_half(div_q)
      && (mr_q + ref_tick_o) * 2 <= mod_half(div_q) + 1)
      else $error("modem tick spacing wrong");
   a_symbol_count : assert property (
      symbol_tick_o |-> $past(modem_tick_o) && sm_q == 4'h8)
      else $error("symbol tick not every eighth modem tick");
   c_seq : cover property ($rose(seq_active_o));
   c_hold : cover property ($fell(rx_en_o) && cs_q);
   c_symbol : cover property (symbol_tick_o);
endmodule : rsa_seq_config_sva
bind rsa_seq_config rsa_seq_config_sva #(.ADC_DIV(ADC_DIV), .FILTER_DIV(FILTER_DIV))
   rsa_seq_config_sva_inst (.*);

// ==== verif/rsa_radio_model.sv ====
// Radio front-end model: synthesizer lock and carrier detector facing the bank.
// Assumes lock follows synthesizer power after a fixed settling time.
`timescale 1ns/1ps
module rsa_radio_model #(
   parameter int LOCK_DLY = 5  // Settling cycles before lock
) (
   input  wire logic sys_clk_i,       // Clock
   input  wire logic rst_i,           // Reset
   input  wire logic synth_en_i,      // Synthesizer powered
   input  wire logic carrier_i,       // Carrier on air
   output logic      synth_lock_o,    // Lock indication
   output logic      carrier_sense_o  // Carrier sensed
);
   int cnt_q;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) cnt_q <= 0;
      else cnt_q <= synth_en_i ? cnt_q + int'(cnt_q < LOCK_DLY) : 0;
   end
   // Lock drops with power, so a stale lock never shortens the next delay
   assign synth_lock_o    = synth_en_i && cnt_q >= LOCK_DLY;
   // With the synthesizer unpowered, nothing is sensed
   assign carrier_sense_o = carrier_i && synth_en_i;
endmodule : rsa_radio_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the setting-A configuration bank.
// Assumes the checker is bound to the design and the radio model answers sequencing.
`timescale 1ns/1ps
module tb_top;
   import rsa_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] q; logic [7:0] r;} rsa_row_t;
   logic        sys_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, carrier = 1'b0;
   logic        cfg_select_i = 1'b1, bidir_data_pin_i = 1'b1;
   logic [7:0]  addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o;
   logic        synth_lock_i, carrier_sense_i, synth_en_o, rx_en_o, seq_active_o;
   logic        synth_a_dither_enable_o, ref_tick_o, modem_tick_o, symbol_tick_o;
   logic [22:0] synth_word_a_o;
   int          mismatches = 0, n_compared = 0;
   rsa_row_t    rows[8] = '{'{OFS_WORD_HIGH, 8'h12, 8'h12, 8'h83}, '{OFS_WORD_MID, 8'h34, 8'h34, 8'hB1},
      '{OFS_WORD_LOW, 8'h56, 8'h56, 8'hF9}, '{OFS_SEQ_TIMING, 8'h70, 8'h70, 8'h8A},
      '{OFS_CLK_DIV_A, 8'hE7, 8'hE7, 8'h50}, '{OFS_SEQ_CTRL, 8'h03, 8'h03, 8'h00},
      '{OFS_SEQ_STATUS, 8'hFF, 8'h00, 8'h00}, '{8'h20, 8'hFF, 8'h00, 8'h00}};
   logic [7:0]  tseq[4] = '{8'h8A, 8'hEF, 8'hF0, 8'h97};
   // Ratios rise row by row up to 8'hF9; the last row, 8'h3E, drops, but its modem divider rises, so no leftover exceeds its own ratio
   logic [7:0]  cdiv[8] = '{8'h30, 8'h43, 8'h67, 8'h8B, 8'hAF, 8'hD5, 8'hF9, 8'h3E};
   rsa_seq_config #(.ADC_DIV(2), .FILTER_DIV(2)) rsa_seq_config_inst (.*);
   rsa_radio_model rsa_radio_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .synth_en_i(synth_en_o), .carrier_i(carrier), .synth_lock_o(synth_lock_i),
      .carrier_sense_o(carrier_sense_i));
   always #20 sys_clk_i = ~sys_clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] q);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 chk(rd_data_o, q);
   endtask : rd
   task automatic wait_sig(input int which, input logic v, input int lim);
      int n = 0;
      logic s = ~v;
      while (s !== v && n < lim) begin
         @(posedge sys_clk_i);
         #1 s = which == 0 ? seq_active_o : which == 1 ? modem_tick_o : symbol_tick_o;
         n++;
      end
      chk(s, v);
   endtask : wait_sig
   task automatic pulse(input logic on_data, input logic starts);
      @(posedge sys_clk_i);
      if (on_data) bidir_data_pin_i <= 1'b0;
      else cfg_select_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      bidir_data_pin_i <= 1'b1;
      cfg_select_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      #1 chk(seq_active_o, starts);
      chk(synth_en_o, starts);
   endtask : pulse
   task automatic finish_test();
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      #(40 * 80000);
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].q);
      end
      chk({synth_word_a_o, synth_a_dither_enable_o}, 32'h0012_3456);
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) rd(rows[i].a, rows[i].r);
      chk({synth_word_a_o, synth_a_dither_enable_o}, 32'h0083_B1F9);
      wr(OFS_CLK_DIV_A, 8'h20);
      repeat (2) wait_sig(2, 1'b1, 600);
      foreach (tseq[i]) begin
         wr(OFS_SEQ_TIMING, tseq[i]);
         pulse(1'b0, 1'b1);
         wait_sig(0, 1'b0, 1500);
      end
      wr(OFS_SEQ_TIMING, 8'h8A);
      pulse(1'b0, 1'b1);
      carrier <= 1'b1;
      repeat (300) @(posedge sys_clk_i);
      #1 chk(rx_en_o, 1'b1);
      rd(OFS_SEQ_STATUS, 8'h04);
      @(posedge sys_clk_i);
      #1 chk(rd_data_o, 8'h00);
      carrier <= 1'b0;
      wait_sig(0, 1'b0, 60);
      wr(OFS_SEQ_TIMING, 8'h70);
      pulse(1'b0, 1'b0);
      pulse(1'b1, 1'b0);
      wr(OFS_SEQ_CTRL, 8'h04);
      pulse(1'b1, 1'b0);
      wr(OFS_SEQ_CTRL, 8'h07);
      pulse(1'b0, 1'b0);
      pulse(1'b1, 1'b1);
      wait_sig(0, 1'b0, 400);
      foreach (cdiv[i]) begin
         wr(OFS_CLK_DIV_A, cdiv[i]);
         repeat (9) wait_sig(1, 1'b1, 1700);
      end
      finish_test();
   end
endmodule : tb_top
